// >>> design/bbe_defs.vh
`ifndef BBE_DEFS_VH
`define BBE_DEFS_VH

// Field geometry
`define BBE_NBEAMS        32
`define BBE_IDXW          5
`define BBE_CNTW          6

// Register word indices on the Avalon address
`define BBE_REG_CTRL      3'h0
`define BBE_REG_MAXB      3'h1
`define BBE_REG_DWELL     3'h2
`define BBE_REG_STATUS    3'h3
`define BBE_REG_RES       3'h4
`define BBE_REG_IRQ_STAT  3'h5
`define BBE_REG_IRQ_MASK  3'h6
`define BBE_REG_BLANKED   3'h7

// Control register fields
`define BBE_CTRL_MODE_LO  0
`define BBE_CTRL_MODE_HI  1
`define BBE_CTRL_RI_EN    2
`define BBE_CTRL_CM_EN    3
`define BBE_CTRL_COARSE   4
`define BBE_CTRL_TEACH    5
`define BBE_CTRL_W        6

// Operating modes
`define BBE_MODE_NORMAL   2'h0
`define BBE_MODE_AUTO     2'h1
`define BBE_MODE_REDUCED  2'h2

// Reset values
`define BBE_CTRL_RST      6'h00
`define BBE_MAXB_RST      6'h01
`define BBE_DWELL_RST     16'h1388
`define BBE_MASK_RST      4'h0

// Interrupt status bits
`define BBE_IRQ_TRIP      0
`define BBE_IRQ_DWELL     1
`define BBE_IRQ_ENTRY     2
`define BBE_IRQ_TEACH     3
`define BBE_IRQ_W         4

// Effective resolution steps in mm
`define BBE_RES_FINE_MM   12'd21
`define BBE_RES_FINE_STEP 12'd7
`define BBE_RES_CRS_MM    12'd47
`define BBE_RES_CRS_STEP  12'd17

// Dwell supervision tick
`define BBE_TICK_US       1000
`define BBE_CLK_MHZ       50

`endif

// >>> design/bbe_run_scan.v
`timescale 1ns/1ps
`include "bbe_defs.vh"

module bbe_run_scan (
  // Beam pattern
  input  wire [`BBE_NBEAMS-1:0] mask_i,
  // Pattern figures
  output reg                    any_o,
  output reg  [`BBE_CNTW-1:0]   count_o,
  output reg  [`BBE_IDXW-1:0]   lo_o,
  output reg  [`BBE_IDXW-1:0]   hi_o,
  output reg                    contig_o,
  output reg  [`BBE_CNTW-1:0]   longest_o
);

  integer                       i;
  reg     [`BBE_CNTW-1:0]       run;

  always @* begin
    any_o     = 1'b0;
    count_o   = {`BBE_CNTW{1'b0}};
    lo_o      = {`BBE_IDXW{1'b0}};
    hi_o      = {`BBE_IDXW{1'b0}};
    longest_o = {`BBE_CNTW{1'b0}};
    run       = {`BBE_CNTW{1'b0}};
    for (i = 0; i < `BBE_NBEAMS; i = i + 1) begin
      if (mask_i[i]) begin
        if (!any_o) begin
          lo_o = i[`BBE_IDXW-1:0];
        end
        any_o   = 1'b1;
        hi_o    = i[`BBE_IDXW-1:0];
        count_o = count_o + 1'b1;
        run     = run + 1'b1;
        if (run > longest_o) begin
          longest_o = run;
        end
      end else begin
        run = {`BBE_CNTW{1'b0}};
      end
    end
    // One unbroken run means the span equals the number of blocked beams
    contig_o = any_o &&
               (count_o == ({1'b0, hi_o} - {1'b0, lo_o} + 1'b1));
  end

endmodule // bbe_run_scan

// >>> design/bbe_evaluator.v
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "bbe_defs.vh"

// Behaviour
// [R01] In auto-floating mode an object is accepted only if it enters at the top or bottom beam.
// [R02] In auto-floating mode only one blanked object may be in the field at a time.
// [R03] The muted beam set follows the beams the tracked object currently blocks.
// [R04] Obstruction wider than the configured maximum blanked beam count is never muted.
// [R05] The dwell of an object in the field is supervised against a configured time limit.
// [R06] When the dwell limit runs out with the object still present both outputs switch off.
// [R07] Any interrupted beam outside the blanked set switches the outputs off; auto-floating mode lets one run that overlaps the set grow into new beams.
// [R08] In auto-floating mode an obstruction that starts mid-field switches the outputs off.
// [R09] With the whole field clear the outputs stay on; the code drops them while the teach bit is set, even with the field clear.
// [R10] Restart inhibit and contactor monitoring are separately selectable in every mode.
// [R11] The host selects and sets up auto-floating mode only over the configuration interface.
// [R12] In auto-floating mode the device drives a muting signal to the warning lamp.
// [R13] In reduced resolution mode objects smaller than the selected resolution never trip.
// [R14] The reduced resolution is learned by teach-in with the intended objects in the field.
// [R15] Taught objects pass anywhere without tripping, and the resulting value is displayed.
// [R16] Beam count maps to resolution in steps, one beam being 21 mm fine or 47 mm coarse.
// [R17] Both safety switching outputs always carry the same state and drop together.
module bbe_evaluator #(
  parameter TICK_CYCLES = `BBE_TICK_US * `BBE_CLK_MHZ
) (
  // Clock and reset
  input  wire                   clk_i,
  input  wire                   reset_n_i,
  // Receiver beam scan
  input  wire [`BBE_NBEAMS-1:0] beams_blocked_i,
  input  wire                   scan_valid_i,
  // Machine side inputs
  input  wire                   restart_i,
  input  wire                   contactor_fb_i,
  // Safety outputs and lamp
  output wire                   safety_switching_output_1_o,
  output wire                   safety_switching_output_2_o,
  output reg                    muting_lamp_o,
  // Resolution display
  output reg  [11:0]            resolution_mm_o,
  // Avalon-MM slave
  input  wire [2:0]             avs_address_i,
  input  wire                   avs_read_i,
  input  wire                   avs_write_i,
  input  wire [31:0]            avs_writedata_i,
  input  wire [3:0]             avs_byteenable_i,
  output reg  [31:0]            avs_readdata_o,
  output wire                   avs_waitrequest_o,
  // Interrupt
  output wire                   irq_o
);

  localparam [1:0] ST_TRIP  = 2'h0;
  localparam [1:0] ST_IDLE  = 2'h1;
  localparam [1:0] ST_TRACK = 2'h2;

  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  be;
    integer      k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        be_merge[k*8 +: 8] = be[k] ? new_v[k*8 +: 8] : old_v[k*8 +: 8];
      end
    end
  endfunction

  function [11:0] res_mm;
    input [`BBE_CNTW-1:0] n;
    input                 coarse;
    reg   [11:0]          steps;
    begin
      steps = (n == {`BBE_CNTW{1'b0}}) ? 12'h000 : {6'h00, n - 1'b1};
      if (coarse) begin
        res_mm = `BBE_RES_CRS_MM + steps * `BBE_RES_CRS_STEP;
      end else begin
        res_mm = `BBE_RES_FINE_MM + steps * `BBE_RES_FINE_STEP;
      end
    end
  endfunction

  reg                       rst_s1_q;
  reg                       rst_s2_q;
  wire                      rst_n;

  reg  [`BBE_CTRL_W-1:0]    ctrl_q;
  reg  [`BBE_CNTW-1:0]      maxb_q;
  reg  [15:0]               dwell_lim_q;
  reg  [`BBE_IRQ_W-1:0]     irq_stat_q;
  reg  [`BBE_IRQ_W-1:0]     irq_mask_q;
  reg                       ack_q;

  reg  [1:0]                state_q;
  reg  [1:0]                state_d;
  reg  [`BBE_NBEAMS-1:0]    blanked_q;
  reg  [`BBE_NBEAMS-1:0]    blanked_d;
  reg  [15:0]               dwell_q;
  reg  [15:0]               tick_cnt_q;
  reg                       field_clear_q;
  reg  [`BBE_CNTW-1:0]      taught_q;
  reg  [`BBE_CNTW-1:0]      teach_max_q;
  reg                       teach_prev_q;

  wire                      any;
  wire [`BBE_CNTW-1:0]      count;
  wire [`BBE_IDXW-1:0]      lo;
  wire [`BBE_IDXW-1:0]      hi;
  wire                      contig;
  wire [`BBE_CNTW-1:0]      longest;

  wire [1:0]                mode;
  wire                      teach;
  wire                      tick;
  wire                      dwell_out;
  wire                      release_ok;
  wire                      acc;
  wire                      wr;
  wire                      rd;
  reg                       bad;
  reg  [`BBE_IRQ_W-1:0]     irq_set;
  wire [31:0]               ctrl_nx;
  wire [31:0]               maxb_nx;
  wire [31:0]               dwell_nx;
  wire [31:0]               mask_nx;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  bbe_run_scan u_scan (
    .mask_i    (beams_blocked_i),
    .any_o     (any),
    .count_o   (count),
    .lo_o      (lo),
    .hi_o      (hi),
    .contig_o  (contig),
    .longest_o (longest)
  );

  assign mode  = ctrl_q[`BBE_CTRL_MODE_HI:`BBE_CTRL_MODE_LO];
  assign teach = ctrl_q[`BBE_CTRL_TEACH];

  // Dwell counts in 1 ms ticks so the limit register spans tens of seconds
  assign tick      = (tick_cnt_q == TICK_CYCLES - 1);
  assign dwell_out = (state_q == ST_TRACK) && (dwell_q >= dwell_lim_q); // [R05]
  // A blocked scan in the release cycle must not turn the outputs back on
  assign release_ok = field_clear_q && !teach && !(scan_valid_i && any) && // [R07]
                      (!ctrl_q[`BBE_CTRL_RI_EN] || restart_i) &&       // [R10]
                      (!ctrl_q[`BBE_CTRL_CM_EN] || contactor_fb_i);    // [R10]

  always @* begin
    bad = 1'b0;
    case (mode)
      `BBE_MODE_AUTO: begin
        if (!any) begin
          bad = 1'b0;                                                  // [R09]
        end else if (state_q == ST_TRACK) begin
          // Growth is allowed only as one run still touching the old set
          bad = !contig || (count > maxb_q) ||                         // [R02] [R04]
                ((beams_blocked_i & blanked_q) == {`BBE_NBEAMS{1'b0}}); // [R07]
        end else begin
          bad = !contig || (count > maxb_q) ||                         // [R04]
                !((lo == {`BBE_IDXW{1'b0}}) ||
                  (hi == `BBE_NBEAMS - 1));                            // [R01] [R08]
        end
      end
      `BBE_MODE_REDUCED: begin
        bad = any && (longest > taught_q);                             // [R13] [R15]
      end
      default: begin
        bad = any;                                                     // [R07]
      end
    endcase
  end

  always @* begin
    state_d   = state_q;
    blanked_d = blanked_q;
    case (state_q)
      ST_TRIP: begin
        blanked_d = {`BBE_NBEAMS{1'b0}};
        if (release_ok) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE, ST_TRACK: begin
        if (teach || dwell_out) begin
          state_d   = ST_TRIP;                                         // [R06]
          blanked_d = {`BBE_NBEAMS{1'b0}};
        end else if (scan_valid_i) begin
          if (bad) begin
            state_d   = ST_TRIP;                                       // [R07]
            blanked_d = {`BBE_NBEAMS{1'b0}};
          end else if ((mode == `BBE_MODE_AUTO) && any) begin
            state_d   = ST_TRACK;
            blanked_d = beams_blocked_i;                               // [R03]
          end else begin
            state_d   = ST_IDLE;
            blanked_d = {`BBE_NBEAMS{1'b0}};
          end
        end
      end
      default: begin
        state_d   = ST_TRIP;
        blanked_d = {`BBE_NBEAMS{1'b0}};
      end
    endcase
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= ST_TRIP;
      blanked_q     <= {`BBE_NBEAMS{1'b0}};
      dwell_q       <= 16'h0000;
      tick_cnt_q    <= 16'h0000;
      field_clear_q <= 1'b0;
      muting_lamp_o <= 1'b0;
    end else begin
      state_q    <= state_d;
      blanked_q  <= blanked_d;
      tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 1'b1;
      if (scan_valid_i) begin
        field_clear_q <= !any;
      end
      if (state_d != ST_TRACK || state_q != ST_TRACK) begin
        dwell_q <= 16'h0000;                                           // [R05]
      end else if (tick && dwell_q != 16'hffff) begin
        dwell_q <= dwell_q + 1'b1;                                     // [R05]
      end
      muting_lamp_o <= (mode == `BBE_MODE_AUTO) && (state_d == ST_TRACK); // [R12]
    end
  end

  // Both channels decode the same compare of state_q against ST_TRIP so they cannot diverge
  assign safety_switching_output_1_o = (state_q != ST_TRIP);          // [R17]
  assign safety_switching_output_2_o = (state_q != ST_TRIP);          // [R17]

  // Teach-in keeps the widest run seen while the teach bit stands
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      taught_q        <= {`BBE_CNTW{1'b0}};
      teach_max_q     <= {`BBE_CNTW{1'b0}};
      teach_prev_q    <= 1'b0;
      resolution_mm_o <= 12'h000;
    end else begin
      teach_prev_q <= teach;
      if (teach && !teach_prev_q) begin
        teach_max_q <= {`BBE_CNTW{1'b0}};
      end else if (teach && scan_valid_i && longest > teach_max_q) begin
        teach_max_q <= longest;                                        // [R14]
      end
      if (!teach && teach_prev_q) begin
        taught_q <= teach_max_q;                                       // [R14]
      end
      if (mode == `BBE_MODE_REDUCED) begin
        resolution_mm_o <= res_mm(taught_q, ctrl_q[`BBE_CTRL_COARSE]); // [R15] [R16]
      end else begin
        resolution_mm_o <= res_mm(maxb_q, ctrl_q[`BBE_CTRL_COARSE]);   // [R16]
      end
    end
  end

  always @* begin
    irq_set = {`BBE_IRQ_W{1'b0}};
    irq_set[`BBE_IRQ_TRIP]  = (state_q != ST_TRIP) && (state_d == ST_TRIP);
    irq_set[`BBE_IRQ_DWELL] = dwell_out;
    irq_set[`BBE_IRQ_ENTRY] = (state_q == ST_IDLE) && (state_d == ST_TRACK);
    irq_set[`BBE_IRQ_TEACH] = !teach && teach_prev_q;
  end

  // One wait state lets read data come from a flip-flop
  assign acc               = (avs_read_i || avs_write_i) && !ack_q;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
  assign wr                = avs_write_i && ack_q;
  assign rd                = avs_read_i && ack_q;
  assign irq_o             = |(irq_stat_q & irq_mask_q);
  assign ctrl_nx  = be_merge({26'h0, ctrl_q}, avs_writedata_i, avs_byteenable_i);
  assign maxb_nx  = be_merge({26'h0, maxb_q}, avs_writedata_i, avs_byteenable_i);
  assign dwell_nx = be_merge({16'h0, dwell_lim_q}, avs_writedata_i, avs_byteenable_i);
  assign mask_nx  = be_merge({28'h0, irq_mask_q}, avs_writedata_i, avs_byteenable_i);

  // Mode and setup change only through this register port
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q         <= `BBE_CTRL_RST;
      maxb_q         <= `BBE_MAXB_RST;
      dwell_lim_q    <= `BBE_DWELL_RST;
      irq_mask_q     <= `BBE_MASK_RST;
      irq_stat_q     <= {`BBE_IRQ_W{1'b0}};
      ack_q          <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end else begin
      ack_q <= acc;
      if (wr) begin
        case (avs_address_i)
          `BBE_REG_CTRL: begin
            ctrl_q <= ctrl_nx[`BBE_CTRL_W-1:0];                        // [R11] [R10]
          end
          `BBE_REG_MAXB: begin
            maxb_q <= maxb_nx[`BBE_CNTW-1:0];                          // [R04]
          end
          `BBE_REG_DWELL: begin
            dwell_lim_q <= dwell_nx[15:0];                             // [R05]
          end
          `BBE_REG_IRQ_MASK: begin
            irq_mask_q <= mask_nx[`BBE_IRQ_W-1:0];
          end
          default: begin
            ctrl_q <= ctrl_q;
          end
        endcase
      end
      // Only bits already handed out are cleared, so an event during the wait survives
      if (rd && avs_address_i == `BBE_REG_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~avs_readdata_o[`BBE_IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
      if (acc && avs_read_i) begin
        case (avs_address_i)
          `BBE_REG_CTRL:     avs_readdata_o <= {26'h0, ctrl_q};
          `BBE_REG_MAXB:     avs_readdata_o <= {26'h0, maxb_q};
          `BBE_REG_DWELL:    avs_readdata_o <= {16'h0, dwell_lim_q};
          `BBE_REG_STATUS:   avs_readdata_o <= {10'h0, taught_q, dwell_q};
          `BBE_REG_RES:      avs_readdata_o <= {20'h0, resolution_mm_o}; // [R15]
          `BBE_REG_IRQ_STAT: avs_readdata_o <= {28'h0, irq_stat_q};
          `BBE_REG_IRQ_MASK: avs_readdata_o <= {28'h0, irq_mask_q};
          `BBE_REG_BLANKED:  avs_readdata_o <= blanked_q;
          default:           avs_readdata_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // bbe_evaluator

// >>> verification/bbe_evaluator_monitor.sv
`timescale 1ns/1ps
`include "bbe_defs.vh"

module bbe_evaluator_monitor #(
  parameter TICK_CYCLES = 4
) (
  // Clock and reset
  input wire                   clk_i,
  input wire                   reset_n_i,
  // Field and machine side
  input wire [`BBE_NBEAMS-1:0] beams_blocked_i,
  input wire                   scan_valid_i,
  input wire                   restart_i,
  input wire                   contactor_fb_i,
  input wire                   safety_switching_output_1_o,
  input wire                   safety_switching_output_2_o,
  input wire                   muting_lamp_o,
  input wire [11:0]            resolution_mm_o,
  // Register bus
  input wire [2:0]             avs_address_i,
  input wire                   avs_read_i,
  input wire                   avs_write_i,
  input wire [31:0]            avs_writedata_i,
  input wire [3:0]             avs_byteenable_i,
  input wire [31:0]            avs_readdata_o,
  input wire                   avs_waitrequest_o,
  input wire                   irq_o
);
  reg  [5:0]  ctrl_q;
  reg  [5:0]  maxb_q;
  wire        wr_ok   = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  wire        is_auto = (ctrl_q[1:0] == `BBE_MODE_AUTO);
  wire        auto_m  = is_auto && !ctrl_q[5];
  wire        outs_on = safety_switching_output_1_o && safety_switching_output_2_o;
  wire [32:0] over    = (33'h2 << maxb_q) - 33'h1;
  wire        scan    = scan_valid_i;
  wire        entry   = scan && auto_m && !muting_lamp_o;

  // Shadow of mode and blank limit, so the rules can be judged from the pins
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= 6'h00;
      maxb_q <= 6'h01;
    end else if (wr_ok) begin
      if (avs_address_i == `BBE_REG_CTRL) ctrl_q <= avs_writedata_i[5:0];
      if (avs_address_i == `BBE_REG_MAXB) maxb_q <= avs_writedata_i[5:0];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_outs_equal: assert property (
    safety_switching_output_1_o == safety_switching_output_2_o) else $error("outputs differ");
  a_bus_one_wait: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus wait too long");
  a_normal_trips: assert property (
    scan && (|beams_blocked_i) && ctrl_q[1] == ctrl_q[0] |=> !outs_on)
    else $error("blocked beam kept outputs on");
  a_mid_entry_trips: assert property (
    entry && (|beams_blocked_i) && !beams_blocked_i[0] && !beams_blocked_i[31] |=> !outs_on)
    else $error("mid entry kept outputs on");
  a_end_entry_mutes: assert property (
    entry && outs_on && maxb_q != 6'h00
    && (beams_blocked_i == 32'h1 || beams_blocked_i == 32'h80000000)
    |=> muting_lamp_o && outs_on) else $error("end entry not muted");
  a_over_max_trips: assert property (
    entry && maxb_q < 6'h1f && beams_blocked_i == over[31:0] |=> !outs_on)
    else $error("oversize object muted");
  a_clear_stays_on: assert property (
    scan && beams_blocked_i == 32'h0 && outs_on && !muting_lamp_o && !ctrl_q[5] |=> outs_on)
    else $error("clear field dropped outputs");
  a_lamp_auto_only: assert property (
    scan && !is_auto |=> !muting_lamp_o) else $error("lamp lit outside auto mode");

  c_tracking: cover property (scan && muting_lamp_o && outs_on);
  c_irq:      cover property (irq_o);
  c_drop:     cover property (outs_on ##1 !outs_on);
endmodule // bbe_evaluator_monitor

bind bbe_evaluator bbe_evaluator_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .beams_blocked_i(beams_blocked_i),
  .scan_valid_i(scan_valid_i), .restart_i(restart_i), .contactor_fb_i(contactor_fb_i),
  .safety_switching_output_1_o(safety_switching_output_1_o),
  .safety_switching_output_2_o(safety_switching_output_2_o),
  .muting_lamp_o(muting_lamp_o), .resolution_mm_o(resolution_mm_o),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));

// >>> verification/bbe_relay_model.sv
`timescale 1ns/1ps

module bbe_relay_model (
  // Clock and outputs under watch
  input  wire  clk_i,
  input  wire  out1_i,
  input  wire  out2_i,
  input  wire  lamp_i,
  // Welded contact when high
  input  wire  stuck_i,
  // Feedback and lamp
  output logic contactor_fb_o = 1'b1,
  output logic lamp_lit_o = 1'b0
);
  logic [1:0] lag_q = 2'b00;

  // Contactor picks up only when both channels agree, and lags by three cycles
  always @(posedge clk_i) begin
    lag_q          <= {lag_q[0], out1_i & out2_i};
    contactor_fb_o <= stuck_i ? 1'b0 : !lag_q[1];
    lamp_lit_o     <= lamp_i;
  end
endmodule // bbe_relay_model

// >>> verification/beam_blanking_evaluator_tb.sv
`timescale 1ns/1ps
`include "bbe_defs.vh"

module beam_blanking_evaluator_tb;
  typedef struct {logic [5:0] ctrl; logic [5:0] maxb; logic [31:0] b; logic on; logic lm;} bbe_row_t;
  logic        clk_i = 0, reset_n_i = 0, scan_valid_i = 0, restart_i = 0;
  logic        rd = 0, wr = 0, stuck = 0, wr_pre = 0;
  logic [31:0] beams = 0, wdata = 0, rdata = 0;
  logic [2:0]  addr = 0;
  wire         o1, o2, lamp, wait_w, irq, fb;
  wire [11:0]  res;
  wire [31:0]  rd_o;
  int          n_mismatch = 0, n_tests = 0;
  bbe_row_t rows[8] = '{
    '{6'h00, 6'h01, 32'h0, 1'b1, 1'b0}, '{6'h00, 6'h01, 32'h100, 1'b0, 1'b0},
    '{6'h03, 6'h01, 32'h1, 1'b0, 1'b0}, '{6'h01, 6'h01, 32'h1, 1'b1, 1'b1},
    '{6'h01, 6'h01, 32'h80000000, 1'b1, 1'b1}, '{6'h01, 6'h03, 32'h10000, 1'b0, 1'b0},
    '{6'h01, 6'h02, 32'h7, 1'b0, 1'b0}, '{6'h01, 6'h03, 32'h5, 1'b0, 1'b0}};

  bbe_evaluator #(.TICK_CYCLES(4)) uut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .beams_blocked_i(beams), .scan_valid_i(scan_valid_i),
    .restart_i(restart_i), .contactor_fb_i(fb), .safety_switching_output_1_o(o1),
    .safety_switching_output_2_o(o2), .muting_lamp_o(lamp), .resolution_mm_o(res),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rd_o), .avs_waitrequest_o(wait_w), .irq_o(irq));
  bbe_relay_model u_relay (.clk_i(clk_i), .out1_i(o1), .out2_i(o2), .lamp_i(lamp),
    .stuck_i(stuck), .contactor_fb_o(fb), .lamp_lit_o());

  initial forever #10 clk_i = ~clk_i;
  // Mid-cycle copy equals what the next rising edge samples
  always @(negedge clk_i) wr_pre = wait_w;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    // Only the watchdog ends a wait that never comes
    do @(posedge clk_i); while (wr_pre !== 1'b0);
    rdata = rd_o;
    rd <= 1'b0;
    wr <= 1'b0;
    @(negedge clk_i);
  endtask

  task scan(input logic [31:0] b);
    @(posedge clk_i);
    beams <= b;
    scan_valid_i <= 1'b1;
    @(posedge clk_i);
    scan_valid_i <= 1'b0;
    @(negedge clk_i);
  endtask

  task clear;
    scan(32'h0);
    repeat (3) @(negedge clk_i);
  endtask

  initial begin
    repeat (30000) @(posedge clk_i);
    n_mismatch++;
    give_verdict;
  end

  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(negedge clk_i);
    chk({o1, o2}, 2'b00);
    chk(res, 12'd21);
    bus(0, `BBE_REG_CTRL, 0); chk(rdata, 32'h0);
    bus(0, `BBE_REG_MAXB, 0); chk(rdata, 32'h1);
    bus(0, `BBE_REG_DWELL, 0); chk(rdata, 32'h1388);
    bus(0, `BBE_REG_IRQ_MASK, 0); chk(rdata, 32'h0);
    foreach (rows[i]) begin
      bus(1, `BBE_REG_CTRL, rows[i].ctrl);
      bus(1, `BBE_REG_MAXB, rows[i].maxb);
      clear;
      scan(rows[i].b);
      chk({o1, o2}, {2{rows[i].on}});
      chk(lamp, rows[i].lm);
      clear;
    end
    // Object grows from the bottom, then shrinks, then a hand reaches in
    bus(1, `BBE_REG_MAXB, 4);
    clear;
    scan(32'h1); scan(32'h3); scan(32'h7);
    bus(0, `BBE_REG_BLANKED, 0); chk(rdata, 32'h7);
    scan(32'h6);
    bus(0, `BBE_REG_BLANKED, 0); chk(rdata, 32'h6);
    scan(32'h1006); chk({o1, o2}, 2'b00);
    // Dwell limit of three ticks, interrupt masked then unmasked
    bus(1, `BBE_REG_DWELL, 3);
    clear;
    bus(0, `BBE_REG_IRQ_STAT, 0);
    scan(32'h1); chk({o1, o2}, 2'b11);
    repeat (20) @(negedge clk_i);
    chk({o1, o2}, 2'b00);
    chk(irq, 1'b0);
    bus(1, `BBE_REG_IRQ_MASK, 2); chk(irq, 1'b1);
    bus(0, `BBE_REG_IRQ_STAT, 0); chk(rdata & 32'h2, 32'h2);
    @(negedge clk_i); chk(irq, 1'b0);
    // Teach a three-beam object in reduced mode
    bus(1, `BBE_REG_CTRL, 6'h22);
    repeat (2) @(negedge clk_i);
    chk({o1, o2}, 2'b00);
    scan(32'h70); scan(32'h0);
    bus(1, `BBE_REG_CTRL, 6'h02);
    clear;
    chk(res, 12'd35);
    bus(0, `BBE_REG_RES, 0); chk(rdata, 32'd35);
    bus(0, `BBE_REG_STATUS, 0); chk(rdata[21:16], 6'd3);
    scan(32'he0000000); chk({o1, o2}, 2'b11);
    scan(32'hf00); chk({o1, o2}, 2'b00);
    bus(1, `BBE_REG_CTRL, 6'h12);
    @(negedge clk_i); chk(res, 12'd81);
    // Restart inhibit holds the trip until acknowledged
    bus(1, `BBE_REG_CTRL, 6'h05);
    clear; chk({o1, o2}, 2'b00);
    @(posedge clk_i); restart_i <= 1'b1;
    repeat (2) @(posedge clk_i); restart_i <= 1'b0;
    @(negedge clk_i); chk({o1, o2}, 2'b11);
    // A welded contactor blocks the release
    bus(1, `BBE_REG_CTRL, 6'h09);
    scan(32'h100);
    @(posedge clk_i); stuck <= 1'b1;
    clear; chk({o1, o2}, 2'b00);
    @(posedge clk_i); stuck <= 1'b0;
    repeat (4) @(posedge clk_i);
    clear; chk({o1, o2}, 2'b11);
    // A second reset mid-run brings back the start values
    @(posedge clk_i); reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i); reset_n_i <= 1'b1;
    repeat (4) @(negedge clk_i);
    chk({o1, o2}, 2'b00);
    chk(res, 12'd21);
    bus(0, `BBE_REG_CTRL, 0); chk(rdata, 32'h0);
    give_verdict;
  end
endmodule // beam_blanking_evaluator_tb
